// ===== src/ptm_pkg.sv
// shared constants for the 10-bit periodic timer: register map, fields, codes
// assumes an 8-bit register port and one 100 MHz system clock
package ptm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 10;
  localparam int PRE_W  = 8;

  // register indices on the byte-wide port
  localparam logic [ADDR_W-1:0] REG_CTRL0  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL1  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CNT_LO = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CNT_HI = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CMPA_LO = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CMPA_HI = 4'h5;
  localparam logic [ADDR_W-1:0] REG_PER_LO = 4'h6;
  localparam logic [ADDR_W-1:0] REG_PER_HI = 4'h7;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;

  // control 0 fields
  localparam int PAUSE_BIT = 7;
  localparam int CKSEL_HI  = 6;
  localparam int CKSEL_LO  = 4;
  localparam int ON_BIT    = 3;
  // control 1 fields
  localparam int MODE_HI    = 7;
  localparam int MODE_LO    = 6;
  localparam int FUNC_HI    = 5;
  localparam int FUNC_LO    = 4;
  localparam int OLC_BIT    = 3;
  localparam int INV_BIT    = 2;
  localparam int CAPSRC_BIT = 1;
  localparam int CLRSEL_BIT = 0;
  // status fields, write one to clear
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam int HI_W       = 2;

  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_ZERO = 10'h000;
  localparam logic [CNT_W:0]    PER_FULL = 11'h400;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } mode_t;

  // output function codes, meaning depends on mode
  localparam logic [1:0] OF_NONE   = 2'b00;
  localparam logic [1:0] OF_LOW    = 2'b01;
  localparam logic [1:0] OF_HIGH   = 2'b10;
  localparam logic [1:0] OF_TOGGLE = 2'b11;
  localparam logic [1:0] OF_INACT  = 2'b00;
  localparam logic [1:0] OF_ACT    = 2'b01;
  localparam logic [1:0] OF_PWM    = 2'b10;
  localparam logic [1:0] OF_SPULSE = 2'b11;
  localparam logic [1:0] OF_RISE   = 2'b00;
  localparam logic [1:0] OF_FALL   = 2'b01;
  localparam logic [1:0] OF_BOTH   = 2'b10;
  localparam logic [1:0] OF_NOCAP  = 2'b11;

  typedef enum logic [2:0] {
    CK_SYS4     = 3'b000,
    CK_SYS      = 3'b001,
    CK_H16      = 3'b010,
    CK_H64      = 3'b011,
    CK_TBC      = 3'b100,
    CK_H        = 3'b101,
    CK_PIN_RISE = 3'b110,
    CK_PIN_FALL = 3'b111
  } cksel_t;

  // prescaler masks: tick when all masked bits are one
  localparam logic [PRE_W-1:0] MASK_4   = 8'h03;
  localparam logic [PRE_W-1:0] MASK_16  = 8'h0f;
  localparam logic [PRE_W-1:0] MASK_64  = 8'h3f;
  localparam logic [PRE_W-1:0] MASK_TBC = 8'hff;
endpackage

// ===== src/pin_sync.sv
// two-flop synchroniser for one pin, with edge pulses taken after it
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;
endmodule

// ===== src/tick_select.sv
// counter clock source: prescaled system clock or a synchronised pin edge
// assumes the high clock equals the system clock; output is a one-cycle enable
`timescale 1ns/1ps
module tick_select (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire ptm_pkg::cksel_t sel,
  input  wire logic         pin_rise,
  input  wire logic         pin_fall,
  output logic              tick
);
  import ptm_pkg::*;
  logic [PRE_W-1:0] pre_ff;
  logic             nxt_tick;

  function automatic logic full(input logic [PRE_W-1:0] v, input logic [PRE_W-1:0] m);
    return (v & m) == m;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 8'h01;
    end
  end

  always_comb begin
    unique case (sel)
      CK_SYS4:     nxt_tick = full(pre_ff, MASK_4);
      CK_SYS:      nxt_tick = 1'b1;
      CK_H16:      nxt_tick = full(pre_ff, MASK_16);
      CK_H64:      nxt_tick = full(pre_ff, MASK_64);
      CK_TBC:      nxt_tick = full(pre_ff, MASK_TBC);
      CK_H:        nxt_tick = 1'b1;
      CK_PIN_RISE: nxt_tick = pin_rise;
      CK_PIN_FALL: nxt_tick = pin_fall;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= nxt_tick;
    end
  end
endmodule

// ===== src/periodic_timer_module.sv
// 10-bit periodic timer: compare output, timer, pwm, single pulse, capture
// assumes one 100 MHz clock and an 8-bit register port, read data one cycle late
//
// Operation
// - mode 00: compare output, two clear sources
// - clear-select low: P match clears, both flags
// - clear-select high: A match clears, no P flag
// - compare A zero: wrap at 3FF, no A flag
// - compare mode: A match moves pin, P match does not
// - A match: high, low, toggle, or hold
// - counter-on rise loads initial output level
// - mode 11: as compare, pin not driven
// - pwm: period clears counter, A sets duty
// - period 1..1023 clocks, zero means 1024
// - duty at or above period: always active
// - pwm raises A and P flags
// - pwm: level, function and invert bits
// - pwm counting continues while pin forced
// - single pulse starts on counter-on rise
// - A match ends pulse, clears counter-on
// - single pulse: clear only on start
// - capture: source bit and edge select
// - active edge copies counter into A
// - capture: free run, P match clears
// - capture function 11 blocks all captures
// - compare function: none, low, high, toggle
// - counter-on rise zeroes, fall holds count
// - capture edges: rise, fall, both
// - pwm function: inactive, active, pwm, pulse
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module periodic_timer_module (
  input  wire logic                       CLK_SYS,
  input  wire logic                       RESET_N,
  input  wire logic [ptm_pkg::ADDR_W-1:0] BUS_ADDR,
  input  wire logic [ptm_pkg::DATA_W-1:0] BUS_WDATA,
  input  wire logic                       BUS_WR,
  input  wire logic                       BUS_RD,
  output logic      [ptm_pkg::DATA_W-1:0] BUS_RDATA,
  input  wire logic                       TIMER_CLOCK_PIN,
  input  wire logic                       CAPTURE_INPUT_PIN,
  output logic                            TIMER_OUT,
  output logic                            TIMER_OUT_EN,
  output logic                            MATCH_A_FLAG,
  output logic                            MATCH_P_FLAG
);
  import ptm_pkg::*;

  logic [DATA_W-1:0] ctrl0_ff;
  logic [DATA_W-1:0] ctrl1_ff;
  logic              on_ff;
  logic              on_prev_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  cmpa_ff;
  logic [CNT_W-1:0]  period_ff;
  logic              lvl_ff;
  logic              nxt_on;
  logic              nxt_lvl;
  logic              nxt_out;
  logic              nxt_drive;
  logic [DATA_W-1:0] nxt_rdata;

  mode_t             mode;
  cksel_t            cksel;
  logic [1:0]        func;
  logic              olc;
  logic              inv;
  logic              pause;
  logic              tick;
  logic              ck_rise;
  logic              ck_fall;
  logic              cap_rise;
  logic              cap_fall;
  logic              on_rise;
  logic              run;
  logic              sp;
  logic              sp_trig;
  logic              cap_evt;
  logic              src_rise;
  logic              src_fall;
  logic [CNT_W:0]    cnt_inc;
  logic [CNT_W:0]    period_len;
  logic              a_hit;
  logic              p_hit;
  logic              a_evt;
  logic              p_evt;
  logic              clr;
  logic              duty_act;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    return a == idx;
  endfunction

  pin_sync u_ck_sync (
    .clk    (CLK_SYS),
    .rst_n  (RESET_N),
    .pin_in (TIMER_CLOCK_PIN),
    .rise   (ck_rise),
    .fall   (ck_fall)
  );

  pin_sync u_cap_sync (
    .clk    (CLK_SYS),
    .rst_n  (RESET_N),
    .pin_in (CAPTURE_INPUT_PIN),
    .rise   (cap_rise),
    .fall   (cap_fall)
  );

  assign mode  = mode_t'(ctrl1_ff[MODE_HI:MODE_LO]);
  assign func  = ctrl1_ff[FUNC_HI:FUNC_LO];
  assign olc   = ctrl1_ff[OLC_BIT];
  assign inv   = ctrl1_ff[INV_BIT];
  assign pause = ctrl0_ff[PAUSE_BIT];
  assign cksel = cksel_t'(ctrl0_ff[CKSEL_HI:CKSEL_LO]);

  tick_select u_tick (
    .clk      (CLK_SYS),
    .rst_n    (RESET_N),
    .sel      (cksel),
    .pin_rise (ck_rise),
    .pin_fall (ck_fall),
    .tick     (tick)
  );

  // control registers; counter-on lives apart since hardware also moves it
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl0_ff <= CTRL_RST;
      ctrl1_ff <= CTRL_RST;
    end else begin
      if (BUS_WR && hit(BUS_ADDR, REG_CTRL0)) begin
        ctrl0_ff <= BUS_WDATA;
      end
      if (BUS_WR && hit(BUS_ADDR, REG_CTRL1)) begin
        ctrl1_ff <= BUS_WDATA;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      period_ff <= CNT_ZERO;
    end else begin
      if (BUS_WR && hit(BUS_ADDR, REG_PER_LO)) begin
        period_ff[DATA_W-1:0] <= BUS_WDATA;
      end
      if (BUS_WR && hit(BUS_ADDR, REG_PER_HI)) begin
        period_ff[CNT_W-1:DATA_W] <= BUS_WDATA[HI_W-1:0];
      end
    end
  end

  assign sp = (mode == MODE_PWM) && (func == OF_SPULSE);
  // pin edge follows the chosen pin clock edge, rising otherwise
  assign sp_trig = (cksel == CK_PIN_FALL) ? ck_fall : ck_rise;

  always_comb begin
    nxt_on = on_ff;
    if (BUS_WR && hit(BUS_ADDR, REG_CTRL0)) begin
      nxt_on = BUS_WDATA[ON_BIT];
    end
    if (sp && a_evt) begin
      nxt_on = 1'b0;
    end else if (sp && !on_ff && sp_trig) begin
      nxt_on = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      on_ff      <= 1'b0;
      on_prev_ff <= 1'b0;
    end else begin
      on_ff      <= nxt_on;
      on_prev_ff <= on_ff;
    end
  end

  assign on_rise = on_ff && !on_prev_ff;
  // the restart cycle only zeroes the count, no tick is taken in it
  assign run = on_ff && !pause && tick && !on_rise;

  assign cnt_inc    = {1'b0, cnt_ff} + 11'h001;
  assign period_len = (period_ff == CNT_ZERO) ? PER_FULL : {1'b0, period_ff};
  assign a_hit      = run && (cmpa_ff != CNT_ZERO) && (cnt_inc == {1'b0, cmpa_ff});
  assign p_hit      = run && (cnt_inc == period_len);

  always_comb begin
    clr   = 1'b0;
    a_evt = 1'b0;
    p_evt = 1'b0;
    unique case (mode)
      MODE_CMP, MODE_TMR: begin
        a_evt = a_hit;
        if (ctrl1_ff[CLRSEL_BIT]) begin
          clr = a_hit;
        end else begin
          clr   = p_hit;
          p_evt = p_hit;
        end
      end
      MODE_PWM: begin
        a_evt = a_hit;
        p_evt = p_hit && !sp;
        clr   = p_hit && !sp;
      end
      MODE_CAP: begin
        p_evt = p_hit;
        clr   = p_hit;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_ff <= CNT_ZERO;
    end else if (on_rise) begin
      cnt_ff <= CNT_ZERO;
    end else if (run) begin
      cnt_ff <= clr ? CNT_ZERO : cnt_inc[CNT_W-1:0];
    end
  end

  assign src_rise = ctrl1_ff[CAPSRC_BIT] ? ck_rise : cap_rise;
  assign src_fall = ctrl1_ff[CAPSRC_BIT] ? ck_fall : cap_fall;

  always_comb begin
    cap_evt = 1'b0;
    if (mode == MODE_CAP) begin
      unique case (func)
        OF_RISE:  cap_evt = src_rise;
        OF_FALL:  cap_evt = src_fall;
        OF_BOTH:  cap_evt = src_rise || src_fall;
        OF_NOCAP: cap_evt = 1'b0;
      endcase
    end
  end

  // a capture wins over a software write in the same cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cmpa_ff <= CNT_ZERO;
    end else if (cap_evt) begin
      cmpa_ff <= cnt_ff;
    end else begin
      if (BUS_WR && hit(BUS_ADDR, REG_CMPA_LO)) begin
        cmpa_ff[DATA_W-1:0] <= BUS_WDATA;
      end
      if (BUS_WR && hit(BUS_ADDR, REG_CMPA_HI)) begin
        cmpa_ff[CNT_W-1:DATA_W] <= BUS_WDATA[HI_W-1:0];
      end
    end
  end

  // flags: a hardware set beats a clear written in the same cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      MATCH_A_FLAG <= 1'b0;
    end else if (a_evt || cap_evt) begin
      MATCH_A_FLAG <= 1'b1;
    end else if (BUS_WR && hit(BUS_ADDR, REG_STATUS) && BUS_WDATA[FLAG_A_BIT]) begin
      MATCH_A_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      MATCH_P_FLAG <= 1'b0;
    end else if (p_evt) begin
      MATCH_P_FLAG <= 1'b1;
    end else if (BUS_WR && hit(BUS_ADDR, REG_STATUS) && BUS_WDATA[FLAG_P_BIT]) begin
      MATCH_P_FLAG <= 1'b0;
    end
  end

  assign duty_act = ({1'b0, cmpa_ff} >= period_len) || (cnt_ff < cmpa_ff);

  // lvl is the pin level before the invert bit
  always_comb begin
    nxt_lvl   = lvl_ff;
    nxt_drive = 1'b0;
    unique case (mode)
      MODE_CMP: begin
        nxt_drive = 1'b1;
        if (on_rise) begin
          nxt_lvl = olc;
        end else if (a_evt) begin
          unique case (func)
            OF_NONE:   nxt_lvl = lvl_ff;
            OF_LOW:    nxt_lvl = 1'b0;
            OF_HIGH:   nxt_lvl = 1'b1;
            OF_TOGGLE: nxt_lvl = !lvl_ff;
          endcase
        end
      end
      MODE_PWM: begin
        nxt_drive = 1'b1;
        unique case (func)
          OF_INACT:  nxt_lvl = !olc;
          OF_ACT:    nxt_lvl = olc;
          OF_PWM:    nxt_lvl = (on_ff && duty_act) ? olc : !olc;
          OF_SPULSE: nxt_lvl = nxt_on ? olc : !olc;
        endcase
      end
      MODE_CAP, MODE_TMR: begin
        nxt_drive = 1'b0;
      end
    endcase
  end

  assign nxt_out = nxt_drive ? (nxt_lvl ^ inv) : 1'b0;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      lvl_ff       <= 1'b0;
      TIMER_OUT    <= 1'b0;
      TIMER_OUT_EN <= 1'b0;
    end else begin
      lvl_ff       <= nxt_lvl;
      TIMER_OUT    <= nxt_out;
      TIMER_OUT_EN <= nxt_drive;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    unique case (BUS_ADDR)
      REG_CTRL0:   nxt_rdata = {ctrl0_ff[PAUSE_BIT:CKSEL_LO], on_ff, 3'h0};
      REG_CTRL1:   nxt_rdata = ctrl1_ff;
      REG_CNT_LO:  nxt_rdata = cnt_ff[DATA_W-1:0];
      REG_CNT_HI:  nxt_rdata = {6'h00, cnt_ff[CNT_W-1:DATA_W]};
      REG_CMPA_LO: nxt_rdata = cmpa_ff[DATA_W-1:0];
      REG_CMPA_HI: nxt_rdata = {6'h00, cmpa_ff[CNT_W-1:DATA_W]};
      REG_PER_LO:  nxt_rdata = period_ff[DATA_W-1:0];
      REG_PER_HI:  nxt_rdata = {6'h00, period_ff[CNT_W-1:DATA_W]};
      REG_STATUS:  nxt_rdata = {6'h00, MATCH_P_FLAG, MATCH_A_FLAG};
      default:     nxt_rdata = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      BUS_RDATA <= '0;
    end else begin
      BUS_RDATA <= BUS_RD ? nxt_rdata : '0;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  chk_restart_zero: assert property (on_rise |=> cnt_ff == CNT_ZERO)
    else $error("counter not zeroed on restart");
  chk_count_step: assert property (run && !clr |=> cnt_ff == $past(cnt_ff) + 10'h001)
    else $error("counter did not step by one");
  chk_no_p_flag: assert property ($rose(MATCH_P_FLAG) |->
      !($past(mode == MODE_CMP || mode == MODE_TMR) && $past(ctrl1_ff[CLRSEL_BIT])))
    else $error("P flag raised with A-match clearing");
  chk_wrap_silent: assert property (run && cnt_ff == {CNT_W{1'b1}} && cmpa_ff == CNT_ZERO
      && (mode == MODE_CMP || mode == MODE_TMR) |=>
      cnt_ff == CNT_ZERO && !$rose(MATCH_A_FLAG))
    else $error("wrong wrap at counter top");
  chk_p_keeps_pin: assert property (mode == MODE_CMP && p_evt && !a_evt && !on_rise
      && $stable(ctrl1_ff) |=> $stable(TIMER_OUT))
    else $error("P match moved the output");
  chk_func_hold: assert property (mode == MODE_CMP && func == OF_NONE && !on_rise
      && $stable(ctrl1_ff) |=> $stable(TIMER_OUT))
    else $error("output moved with no-change function");
  chk_init_level: assert property (mode == MODE_CMP && on_rise |=> TIMER_OUT == $past(olc ^ inv))
    else $error("output not at initial level after restart");
  chk_timer_undriven: assert property (mode == MODE_TMR |=> !TIMER_OUT_EN)
    else $error("output driven in timer mode");
  chk_full_duty: assert property (mode == MODE_PWM && func == OF_PWM && on_ff
      && ({1'b0, cmpa_ff} >= period_len) |=> TIMER_OUT == $past(olc ^ inv))
    else $error("full duty not held active");
  chk_pulse_end: assert property (sp && a_evt |=> !on_ff && TIMER_OUT == $past(!olc ^ inv))
    else $error("pulse not ended by A match");
  chk_capture_copy: assert property (cap_evt |=> cmpa_ff == $past(cnt_ff) && MATCH_A_FLAG)
    else $error("capture did not copy counter");
  chk_capture_off: assert property (mode == MODE_CAP && func == OF_NOCAP && !BUS_WR
      |=> $stable(cmpa_ff))
    else $error("capture taken while disabled");
endmodule

// ===== testbench/timer_pins_model.sv
// far-side pins of the timer: external clock pin and capture pin
// assumes the bench calls its tasks from the system clock domain; pins idle low
`timescale 1ns/1ps
module timer_pins_model (
  input  wire logic clk,
  output logic      clock_pin,
  output logic      capture_pin
);
  initial begin
    clock_pin   = 1'b0;
    capture_pin = 1'b0;
  end

  // an edge here may also launch a single pulse, so it moves only after an edge
  task automatic drive_clock(input logic lvl);
    @(posedge clk);
    clock_pin <= lvl;
  endtask

  task automatic drive_capture(input logic lvl);
    @(posedge clk);
    capture_pin <= lvl;
  endtask
endmodule

// ===== testbench/periodic_timer_module_tb.sv
// self-checking bench for the periodic timer: bus tasks and scenarios for every mode
// assumes the pin model on the far side and a 100 MHz system clock
`timescale 1ns/1ps
module periodic_timer_module_tb;
  import ptm_pkg::*;
  logic              clk_sys;
  logic              reset_n;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [DATA_W-1:0] bus_rdata;
  logic              clock_pin;
  logic              capture_pin;
  logic              timer_out;
  logic              timer_out_en;
  logic              flag_a;
  logic              flag_p;
  int                fail_count;
  int                checks_done;
  logic [7:0]        rv;
  logic [7:0]        rv2;
  int                hi;
  bit                seen;

  periodic_timer_module dut (
    .CLK_SYS           (clk_sys),
    .RESET_N           (reset_n),
    .BUS_ADDR          (bus_addr),
    .BUS_WDATA         (bus_wdata),
    .BUS_WR            (bus_wr),
    .BUS_RD            (bus_rd),
    .BUS_RDATA         (bus_rdata),
    .TIMER_CLOCK_PIN   (clock_pin),
    .CAPTURE_INPUT_PIN (capture_pin),
    .TIMER_OUT         (timer_out),
    .TIMER_OUT_EN      (timer_out_en),
    .MATCH_A_FLAG      (flag_a),
    .MATCH_P_FLAG      (flag_p)
  );
  timer_pins_model pins (
    .clk         (clk_sys),
    .clock_pin   (clock_pin),
    .capture_pin (capture_pin)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one idle edge between strobes keeps each strobe assignment in its own time step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_sig(input int which, input int lim, output bit hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      settle(1);
      hit = (which == 0) ? (flag_a === 1'b1) : (which == 1) ? (flag_p === 1'b1) : (timer_out === 1'b1);
    end
  endtask

  task automatic count_hi(input int n, output int c);
    c = 0;
    repeat (n) begin
      settle(1);
      if (timer_out === 1'b1) c++;
    end
  endtask

  task automatic setv(input logic [9:0] a, input logic [9:0] p);
    wr(REG_CMPA_LO, a[7:0]);
    wr(REG_CMPA_HI, {6'b0, a[9:8]});
    wr(REG_PER_LO, p[7:0]);
    wr(REG_PER_HI, {6'b0, p[9:8]});
  endtask

  // mode and function change only while the counter is off
  task automatic start(input logic [7:0] c1, input logic [2:0] ck);
    wr(REG_CTRL0, 8'h00);
    wr(REG_CTRL1, c1);
    wr(REG_STATUS, 8'h03);
    wr(REG_CTRL0, {1'b0, ck, 1'b1, 3'b000});
  endtask

  task automatic pwm(input logic [1:0] f, input logic inv, input logic [9:0] a, input logic [9:0] p,
                     input int win, input int exp);
    int c;
    setv(a, p);
    start({2'b10, f, 1'b1, inv, 2'b00}, CK_SYS);
    settle(30);
    count_hi(win, c);
    chk(c, exp);
  endtask

  initial begin
    #300_000;
    fail_count++;
    final_report();
  end

  initial begin
    fail_count  = 0;
    checks_done = 0;
    reset_n     = 1'b0;
    bus_addr    = '0;
    bus_wdata   = '0;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rv);
      chk(rv, 0);
    end
    wr(REG_PER_HI, 8'hff);
    rd(REG_PER_HI, rv);
    chk(rv, 8'h03);
    wr(REG_PER_LO, 8'ha5);
    rd(REG_PER_LO, rv);
    chk(rv, 8'ha5);
    wr(REG_CNT_LO, 8'hff);
    rd(REG_CNT_LO, rv);
    chk(rv, 0);
    // compare output, initial level high, every output function
    setv(10'd40, 10'd80);
    for (int f = 0; f < 4; f++) begin
      start({2'b00, f[1:0], 4'b1000}, CK_SYS4);
      settle(10);
      chk(timer_out, 1);
      chk(timer_out_en, 1);
      wait_sig(0, 400, seen);
      chk(seen, 1);
      chk(timer_out, (f == 1 || f == 3) ? 0 : 1);
      wait_sig(1, 400, seen);
      chk(seen, 1);
      chk(timer_out, (f == 1 || f == 3) ? 0 : 1);
    end
    wr(REG_CTRL0, 8'h00);
    rd(REG_CNT_LO, rv);
    settle(20);
    rd(REG_CNT_LO, rv2);
    chk(rv2, rv);
    setv(10'd20, 10'd3);
    start(8'h01, CK_SYS);
    wait_sig(0, 100, seen);
    chk(seen, 1);
    settle(200);
    chk(flag_p, 0);
    setv(10'd0, 10'd0);
    start(8'hc0, CK_SYS);
    settle(1100);
    chk(flag_a, 0);
    chk(flag_p, 1);
    chk(timer_out_en, 0);
    wr(REG_CTRL0, 8'h98);
    rd(REG_CNT_LO, rv);
    settle(50);
    rd(REG_CNT_LO, rv2);
    chk(rv2, rv);
    pwm(OF_PWM, 1'b0, 10'd3, 10'd8, 80, 30);
    pwm(OF_PWM, 1'b1, 10'd3, 10'd8, 80, 50);
    pwm(OF_PWM, 1'b0, 10'd8, 10'd8, 80, 80);
    pwm(OF_PWM, 1'b0, 10'd512, 10'd0, 2048, 1024);
    pwm(OF_ACT, 1'b0, 10'd3, 10'd8, 80, 80);
    pwm(OF_INACT, 1'b0, 10'd3, 10'd8, 80, 0);
    wr(REG_STATUS, 8'h03);
    wait_sig(0, 20, seen);
    chk(seen, 1);
    wait_sig(1, 20, seen);
    chk(seen, 1);
    // single pulse, by software and then by the clock pin
    setv(10'd50, 10'd0);
    start(8'hb8, CK_SYS);
    count_hi(150, hi);
    chk(hi >= 49 && hi <= 51, 1);
    rd(REG_CTRL0, rv);
    chk(rv[ON_BIT], 0);
    wr(REG_CTRL0, 8'h10);
    pins.drive_clock(1'b1);
    wait_sig(2, 20, seen);
    chk(seen, 1);
    pins.drive_clock(1'b0);
    // capture edges with the counter off
    setv(10'd0, 10'd0);
    wr(REG_CTRL0, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(REG_CTRL1, {2'b01, f[1:0], 4'b0000});
      wr(REG_STATUS, 8'h03);
      pins.drive_capture(1'b1);
      settle(8);
      chk(flag_a, f == 0 || f == 2);
      wr(REG_STATUS, 8'h03);
      pins.drive_capture(1'b0);
      settle(8);
      chk(flag_a, f == 1 || f == 2);
    end
    wr(REG_CTRL1, 8'h42);
    wr(REG_STATUS, 8'h03);
    pins.drive_capture(1'b1);
    settle(8);
    chk(flag_a, 0);
    pins.drive_clock(1'b1);
    settle(8);
    chk(flag_a, 1);
    pins.drive_capture(1'b0);
    pins.drive_clock(1'b0);
    start(8'h40, CK_SYS4);
    settle(200);
    rd(REG_CNT_LO, rv);
    pins.drive_capture(1'b1);
    settle(8);
    rd(REG_CMPA_LO, rv2);
    chk(rv2 - rv <= 2, 1);
    setv(10'd0, 10'd5);
    start(8'h40, CK_SYS);
    wait_sig(1, 40, seen);
    chk(seen, 1);
    // counting on pin edges, then on the divided clock
    start(8'hc0, CK_PIN_RISE);
    repeat (3) begin
      pins.drive_clock(1'b1);
      pins.drive_clock(1'b0);
      settle(4);
    end
    rd(REG_CNT_LO, rv);
    chk(rv, 8'h03);
    wr(REG_PER_LO, 8'h00);
    start(8'hc0, CK_H16);
    settle(320);
    rd(REG_CNT_LO, rv);
    chk(rv >= 19 && rv <= 21, 1);
    final_report();
  end
endmodule
